//--- rtl/icw_pkg.sv
// Purpose: shared constants and types for the command word and scl high-period block
// Assumes: 32-bit register port, byte offsets as printed
// Notes:   link-side states are one-hot
`default_nettype none

package icw_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          HCNT_W       = 16;
  localparam int          CMD_W        = 10;
  localparam int          BYTE_W       = 8;

  // register offsets
  localparam logic [7:0]  OFS_DATA_CMD = 8'h10;
  localparam logic [7:0]  OFS_SS_HCNT  = 8'h14;

  // command word fields
  localparam int          BIT_STOP     = 9;
  localparam int          BIT_DIR      = 8;

  // high-period count
  localparam logic [15:0] HCNT_RESET   = 16'h0028;
  localparam logic [15:0] HCNT_MIN     = 16'h0006;
  localparam logic [15:0] HCNT_MAX     = 16'hfff5;
  localparam int          IDLE_MARGIN  = 10;

  // scl low period in link clock cycles, low-count register is not part of this block
  localparam logic [15:0] SCL_LOW_CNT  = 16'h002f;

  // bit index of the acknowledge slot within a byte
  localparam logic [3:0]  ACK_SLOT     = 4'h8;

  typedef enum logic [4:0] {
    L_IDLE  = 5'h01,
    L_START = 5'h02,
    L_BIT   = 5'h04,
    L_STOP  = 5'h08,
    L_HOLD  = 5'h10
  } icw_lstate_t;

endpackage

`default_nettype wire

//--- rtl/icw_sync.sv
// Purpose: two-flop level synchroniser, W bits wide
// Assumes: each bit is an independent level or toggle
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none

module icw_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  initial begin
    if (W < 1) $error("icw_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } icw_sync_t;

  icw_sync_t st_reg;
  icw_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule

`default_nettype wire

//--- rtl/icw_idle_det.sv
// Purpose: bus idle detector on the link clock
// Assumes: scl and sda already synchronised
// Notes:   counter saturates, so a long idle stays flagged
`timescale 1ns/1ps
`default_nettype none

module icw_idle_det #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // bus lines and threshold
  input  wire logic         scl,
  input  wire logic         sda,
  input  wire logic [W-1:0] hcnt,
  // status
  output var  logic         idle
);

  initial begin
    if (W != icw_pkg::HCNT_W) $error("icw_idle_det: W must match the high-period count width");
  end

  localparam logic [W:0] MARGIN = (W+1)'(icw_pkg::IDLE_MARGIN);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         idle;
  } icw_idle_t;

  icw_idle_t st_reg;
  icw_idle_t st_next;
  logic      reached;

  // 17-bit compare so hcnt + 10 cannot wrap
  assign reached = ({1'b0, st_reg.cnt} >= ({1'b0, hcnt} + MARGIN));

  always_comb begin
    st_next = st_reg;
    if (scl && sda) begin
      if (st_reg.cnt != '1) begin
        st_next.cnt = st_reg.cnt + W'(1);
      end
    end else begin
      st_next.cnt = '0;
    end
    st_next.idle = reached; // see RL14
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign idle = st_reg.idle;

  property p_idle_thr;
    @(posedge clk) disable iff (!rst_b) reached |=> idle;
  endproperty
  a_idle_thr: assert property (p_idle_thr) else $error("idle not flagged at threshold"); // see RL14

  property p_idle_drop;
    @(posedge clk) disable iff (!rst_b) (!scl && hcnt != '1) |-> ##2 !idle;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("idle kept while scl low"); // see RL14

endmodule

`default_nettype wire

//--- rtl/icw_top.sv
// Purpose: command word decode, scl high-period count and a small controller engine
// Assumes: tx and rx queues live outside; ctrl_enable is enable bit 0
// Notes:   engine runs on link_clk; crossings use toggles and two-flop syncs
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RL1 - stop bit set: issue stop after byte
// RL2 - stop then queued work: start and arbitrate
// RL3 - stop clear: continue transfer per direction
// RL4 - stop clear, queue empty: hold scl low
// RL5 - direction bit: 0 write, 1 read, controller only
// RL6 - target: direction ignored, words supply bytes
// RL7 - read after general call raises abort
// RL8 - direction 1 after read request aborts
// RL9 - payload sent; reads return received byte
// RL10 - high count resets 0x0028, counts link cycles
// RL11 - high count writable only while disabled
// RL12 - high count below six stores six
// RL13 - narrow bus: low byte written first; this block has only the 32-bit register port
// RL14 - idle flagged at high count plus ten
// RL15 - write pushes tx queue, read pops rx
// RL16 - software queues one read per byte
// RL17 - stop and direction self-clear, read zero
module icw_top #(
  parameter logic [15:0] LOW_CNT = icw_pkg::SCL_LOW_CNT
) (
  // clocks and reset
  input  wire logic        ref_clk,
  input  wire logic        link_clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output var  logic [31:0] reg_rdata,
  // unit control and status
  input  wire logic        ctrl_enable,
  input  wire logic        target_mode,
  input  wire logic        gc_sent,
  input  wire logic        tar_target_select_a,
  input  wire logic        rd_req,
  output var  logic        transmit_abort_flag,
  output var  logic        bus_idle,
  // transmit queue
  output var  logic        tx_push,
  output var  logic [9:0]  tx_word,
  input  wire logic        txq_valid,
  input  wire logic [9:0]  txq_word,
  output var  logic        txq_pop,
  // receive queue
  output var  logic        rx_push,
  output var  logic [7:0]  rx_push_byte,
  input  wire logic        rx_empty,
  input  wire logic [7:0]  rx_head,
  output var  logic        rx_pop,
  // i2c pins
  input  wire logic        scl_in,
  output var  logic        scl_out,
  output var  logic        scl_oe_b,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe_b
);

  initial begin
    if (LOW_CNT < 16'h0001) $error("icw_top: LOW_CNT must be at least 1");
  end

  typedef struct packed {
    logic [15:0] hcnt;
    logic        hcnt_tgl;
    logic [9:0]  slot;
    logic        slot_full;
    logic        req_tgl;
    logic        ack_d;
    logic        rx_d;
    logic        ab_d;
    logic        abort;
    logic        rdreq_seen;
    logic        txq_pop;
    logic        tx_push;
    logic [9:0]  tx_word;
    logic        rx_pop;
    logic        rx_push;
    logic [7:0]  rx_byte;
    logic [31:0] rdata;
    logic        bus_idle;
  } icw_ref_t;

  typedef struct packed {
    icw_pkg::icw_lstate_t st;
    logic [15:0] cnt;
    logic        hi;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        rd;
    logic        stop;
    logic        pend;
    logic [9:0]  pword;
    logic        req_d;
    logic        hcnt_d;
    logic [15:0] hcnt;
    logic        ack_tgl;
    logic        rx_tgl;
    logic [7:0]  rx_byte;
    logic        ab_tgl;
    logic        scl_o;
    logic        sda_o;
    logic        scl_oe_b;
    logic        sda_oe_b;
  } icw_link_t;

  icw_ref_t  r_reg;
  icw_ref_t  r_next;
  icw_link_t l_reg;
  icw_link_t l_next;

  logic [4:0] lsync_q;
  logic [3:0] rsync_q;
  logic       idle_l;
  logic       req_s;
  logic       hcnt_s;
  logic       en_s;
  logic       scl_s;
  logic       sda_s;
  logic       ack_s;
  logic       rxt_s;
  logic       abt_s;
  logic       idle_s;
  logic       wr_data;
  logic       wr_hcnt;
  logic       rd_data;
  logic       hi_done;
  logic       byte_end;

  //////////////////////////////////////////////////////////////////////////////
  // crossings

  icw_sync #(.W(5)) u_lsync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .d     ({r_reg.req_tgl, r_reg.hcnt_tgl, ctrl_enable, scl_in, sda_in}),
    .q     (lsync_q)
  );

  icw_sync #(.W(4)) u_rsync (
    .clk   (ref_clk),
    .rst_b (rst_b),
    .d     ({l_reg.ack_tgl, l_reg.rx_tgl, l_reg.ab_tgl, idle_l}),
    .q     (rsync_q)
  );

  assign {req_s, hcnt_s, en_s, scl_s, sda_s} = lsync_q;
  assign {ack_s, rxt_s, abt_s, idle_s}       = rsync_q;

  icw_idle_det #(.W(icw_pkg::HCNT_W)) u_idle (
    .clk   (link_clk),
    .rst_b (rst_b),
    .scl   (scl_s),
    .sda   (sda_s),
    .hcnt  (l_reg.hcnt),
    .idle  (idle_l)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register side

  assign wr_data = reg_wr && (reg_addr == icw_pkg::OFS_DATA_CMD);
  assign wr_hcnt = reg_wr && (reg_addr == icw_pkg::OFS_SS_HCNT);
  assign rd_data = reg_rd && (reg_addr == icw_pkg::OFS_DATA_CMD);

  always_comb begin
    r_next         = r_reg;
    r_next.abort   = 1'b0;
    r_next.txq_pop = 1'b0;
    r_next.tx_push = 1'b0;
    r_next.rx_pop  = 1'b0;
    r_next.rx_push = 1'b0;
    r_next.ack_d   = ack_s;
    r_next.rx_d    = rxt_s;
    r_next.ab_d    = abt_s;
    r_next.bus_idle = idle_s;
    // enabled writes are dropped; count is stable while the engine uses it
    if (wr_hcnt && !ctrl_enable) begin // see RL11
      r_next.hcnt     = (reg_wdata[15:0] < icw_pkg::HCNT_MIN) ? icw_pkg::HCNT_MIN : reg_wdata[15:0]; // see RL12
      r_next.hcnt_tgl = ~r_reg.hcnt_tgl;
    end
    if (wr_data) begin
      r_next.tx_push    = 1'b1; // see RL15
      r_next.tx_word    = reg_wdata[9:0];
      r_next.rdreq_seen = 1'b0;
      if (reg_wdata[icw_pkg::BIT_DIR] && !target_mode && gc_sent && tar_target_select_a) begin
        r_next.abort = 1'b1; // see RL7
      end
      if (reg_wdata[icw_pkg::BIT_DIR] && target_mode && r_reg.rdreq_seen) begin
        r_next.abort = 1'b1; // see RL8
      end
    end
    // set wins over the clear by the data write
    if (rd_req) begin
      r_next.rdreq_seen = 1'b1;
    end
    if (abt_s != r_reg.ab_d) begin
      r_next.abort = 1'b1;
    end
    if (reg_rd) begin
      if (rd_data) begin
        r_next.rdata  = {24'h000000, rx_head}; // see RL9, RL17
        r_next.rx_pop = !rx_empty; // see RL15
      end else if (reg_addr == icw_pkg::OFS_SS_HCNT) begin
        r_next.rdata = {16'h0000, r_reg.hcnt};
      end else begin
        r_next.rdata = 32'h00000000;
      end
    end
    if (ack_s != r_reg.ack_d) begin
      r_next.slot_full = 1'b0;
    end
    // target mode leaves the queue to the target path, direction unused here
    if (!r_reg.slot_full && txq_valid && !r_reg.txq_pop && !target_mode) begin // see RL5, RL6
      r_next.slot      = txq_word;
      r_next.slot_full = 1'b1;
      r_next.req_tgl   = ~r_reg.req_tgl;
      r_next.txq_pop   = 1'b1;
    end
    if (rxt_s != r_reg.rx_d) begin
      r_next.rx_push = 1'b1;
      r_next.rx_byte = l_reg.rx_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg      <= '0;
      r_reg.hcnt <= icw_pkg::HCNT_RESET; // see RL10
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata           = r_reg.rdata;
  assign transmit_abort_flag = r_reg.abort;
  assign bus_idle            = r_reg.bus_idle;
  assign tx_push             = r_reg.tx_push;
  assign tx_word             = r_reg.tx_word;
  assign txq_pop             = r_reg.txq_pop;
  assign rx_push             = r_reg.rx_push;
  assign rx_push_byte        = r_reg.rx_byte;
  assign rx_pop              = r_reg.rx_pop;

  //////////////////////////////////////////////////////////////////////////////
  // link side engine

  assign hi_done  = l_reg.hi && scl_s && ((l_reg.cnt + 16'h0001) >= l_reg.hcnt);
  assign byte_end = (l_reg.st == icw_pkg::L_BIT) && hi_done && (l_reg.bitn == icw_pkg::ACK_SLOT);

  always_comb begin
    l_next = l_reg;
    if (hcnt_s != l_reg.hcnt_d) begin
      l_next.hcnt_d = hcnt_s;
      l_next.hcnt   = r_reg.hcnt;
    end
    // one word in flight; the toggle waits until the last word is consumed
    if ((req_s != l_reg.req_d) && !l_reg.pend) begin
      l_next.req_d   = req_s;
      l_next.pword   = r_reg.slot;
      l_next.pend    = 1'b1;
      l_next.ack_tgl = ~l_reg.ack_tgl;
    end
    case (l_reg.st)
      icw_pkg::L_IDLE: begin
        l_next.scl_oe_b = 1'b1;
        l_next.sda_oe_b = 1'b1;
        if (l_reg.pend && en_s) begin
          l_next.st       = icw_pkg::L_START; // see RL2
          l_next.cnt      = 16'h0000;
          l_next.sda_oe_b = 1'b0;
        end
      end
      icw_pkg::L_START: begin
        if ((l_reg.cnt + 16'h0001) >= l_reg.hcnt) begin
          l_next.st       = icw_pkg::L_BIT;
          l_next.scl_oe_b = 1'b0;
          l_next.cnt      = 16'h0000;
          l_next.hi       = 1'b0;
          l_next.bitn     = 4'h0;
          l_next.sh       = l_reg.pword[7:0];
          l_next.rd       = l_reg.pword[icw_pkg::BIT_DIR];
          l_next.stop     = l_reg.pword[icw_pkg::BIT_STOP];
          l_next.pend     = 1'b0;
        end else begin
          l_next.cnt = l_reg.cnt + 16'h0001;
        end
      end
      icw_pkg::L_BIT: begin
        if (!l_reg.hi) begin
          if (l_reg.bitn == icw_pkg::ACK_SLOT) begin
            // ack a read only while another read is queued
            l_next.sda_oe_b = !(l_reg.rd && l_reg.pend && l_reg.pword[icw_pkg::BIT_DIR]);
          end else begin
            l_next.sda_oe_b = l_reg.rd ? 1'b1 : l_reg.sh[7]; // see RL5, RL9
          end
          if ((l_reg.cnt + 16'h0001) >= LOW_CNT) begin
            l_next.hi       = 1'b1;
            l_next.cnt      = 16'h0000;
            l_next.scl_oe_b = 1'b1;
          end else begin
            l_next.cnt = l_reg.cnt + 16'h0001;
          end
        end else if (!scl_s) begin
          // target stretching; high time counts from the seen rising edge
          l_next.cnt = 16'h0000;
        end else if (hi_done) begin
          l_next.hi       = 1'b0;
          l_next.cnt      = 16'h0000;
          l_next.scl_oe_b = 1'b0;
          l_next.bitn     = l_reg.bitn + 4'h1;
          if (l_reg.bitn != icw_pkg::ACK_SLOT) begin
            l_next.sh = {l_reg.sh[6:0], l_reg.rd ? sda_s : 1'b0};
            if (!l_reg.rd && l_reg.sh[7] && !sda_s) begin
              // lost arbitration: free the bus and report
              l_next.ab_tgl   = ~l_reg.ab_tgl;
              l_next.scl_oe_b = 1'b1;
              l_next.sda_oe_b = 1'b1;
              l_next.st       = icw_pkg::L_IDLE;
            end
          end else begin
            if (l_reg.rd) begin
              l_next.rx_byte = l_reg.sh;
              l_next.rx_tgl  = ~l_reg.rx_tgl;
            end
            if (l_reg.stop) begin
              // sda drops one cycle after scl falls, so no false start
              l_next.st       = icw_pkg::L_STOP; // see RL1
            end else if (l_reg.pend) begin
              l_next.bitn = 4'h0; // see RL3
              l_next.sh   = l_reg.pword[7:0];
              l_next.rd   = l_reg.pword[icw_pkg::BIT_DIR];
              l_next.stop = l_reg.pword[icw_pkg::BIT_STOP];
              l_next.pend = 1'b0;
            end else begin
              l_next.st = icw_pkg::L_HOLD; // see RL4
            end
          end
        end else begin
          l_next.cnt = l_reg.cnt + 16'h0001;
        end
      end
      icw_pkg::L_HOLD: begin
        l_next.scl_oe_b = 1'b0; // see RL4
        if (l_reg.pend) begin
          l_next.st   = icw_pkg::L_BIT;
          l_next.cnt  = 16'h0000;
          l_next.hi   = 1'b0;
          l_next.bitn = 4'h0;
          l_next.sh   = l_reg.pword[7:0];
          l_next.rd   = l_reg.pword[icw_pkg::BIT_DIR]; // see RL17
          l_next.stop = l_reg.pword[icw_pkg::BIT_STOP];
          l_next.pend = 1'b0;
        end
      end
      icw_pkg::L_STOP: begin
        l_next.sda_oe_b = l_reg.sda_oe_b;
        if (!l_reg.hi) begin
          l_next.sda_oe_b = 1'b0;
          if ((l_reg.cnt + 16'h0001) >= LOW_CNT) begin
            l_next.hi       = 1'b1;
            l_next.cnt      = 16'h0000;
            l_next.scl_oe_b = 1'b1;
          end else begin
            l_next.cnt = l_reg.cnt + 16'h0001;
          end
        end else if (hi_done) begin
          l_next.sda_oe_b = 1'b1; // see RL1
          l_next.hi       = 1'b0;
          l_next.cnt      = 16'h0000;
          l_next.st       = icw_pkg::L_IDLE;
        end else if (scl_s) begin
          l_next.cnt = l_reg.cnt + 16'h0001;
        end
      end
      default: begin
        l_next.st       = icw_pkg::L_IDLE;
        l_next.scl_oe_b = 1'b1;
        l_next.sda_oe_b = 1'b1;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      l_reg          <= '0;
      l_reg.st       <= icw_pkg::L_IDLE;
      l_reg.hcnt     <= icw_pkg::HCNT_RESET;
      l_reg.scl_oe_b <= 1'b1;
      l_reg.sda_oe_b <= 1'b1;
    end else begin
      l_reg <= l_next;
    end
  end

  assign scl_out  = l_reg.scl_o;
  assign sda_out  = l_reg.sda_o;
  assign scl_oe_b = l_reg.scl_oe_b;
  assign sda_oe_b = l_reg.sda_oe_b;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  property p_hcnt_locked;
    @(posedge ref_clk) disable iff (!rst_b) (wr_hcnt && ctrl_enable) |=> $stable(r_reg.hcnt);
  endproperty
  a_hcnt_locked: assert property (p_hcnt_locked) else $error("count changed while enabled"); // see RL11

  property p_hcnt_clamp;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_hcnt && !ctrl_enable && reg_wdata[15:0] < icw_pkg::HCNT_MIN) |=> (r_reg.hcnt == icw_pkg::HCNT_MIN);
  endproperty
  a_hcnt_clamp: assert property (p_hcnt_clamp) else $error("small count not clamped"); // see RL12

  property p_hcnt_store;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_hcnt && !ctrl_enable && reg_wdata[15:0] >= icw_pkg::HCNT_MIN) |=> (r_reg.hcnt == $past(reg_wdata[15:0]));
  endproperty
  a_hcnt_store: assert property (p_hcnt_store) else $error("count not stored"); // see RL10

  property p_push;
    @(posedge ref_clk) disable iff (!rst_b) wr_data |=> (tx_push && tx_word == $past(reg_wdata[9:0]));
  endproperty
  a_push: assert property (p_push) else $error("command write not pushed"); // see RL15

  property p_pop;
    @(posedge ref_clk) disable iff (!rst_b)
      (rd_data && !rx_empty) |=> (rx_pop && reg_rdata == {24'h000000, $past(rx_head)});
  endproperty
  a_pop: assert property (p_pop) else $error("data read did not pop or return byte"); // see RL9

  property p_gc_abort;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_data && reg_wdata[icw_pkg::BIT_DIR] && !target_mode && gc_sent && tar_target_select_a) |=> transmit_abort_flag;
  endproperty
  a_gc_abort: assert property (p_gc_abort) else $error("read after general call not aborted"); // see RL7

  property p_rdreq_abort;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_data && reg_wdata[icw_pkg::BIT_DIR] && target_mode && r_reg.rdreq_seen) |=> transmit_abort_flag;
  endproperty
  a_rdreq_abort: assert property (p_rdreq_abort) else $error("read bit after read request not aborted"); // see RL8

  property p_stop_after;
    @(posedge link_clk) disable iff (!rst_b)
      (byte_end && l_reg.stop) |=> (l_reg.st == icw_pkg::L_STOP && !scl_oe_b) ##1 !sda_oe_b;
  endproperty
  a_stop_after: assert property (p_stop_after) else $error("no stop after stop byte"); // see RL1

  property p_restart;
    @(posedge link_clk) disable iff (!rst_b)
      (l_reg.st == icw_pkg::L_IDLE && l_reg.pend && en_s) |=> (l_reg.st == icw_pkg::L_START && !sda_oe_b);
  endproperty
  a_restart: assert property (p_restart) else $error("queued work did not start"); // see RL2

  property p_continue;
    @(posedge link_clk) disable iff (!rst_b)
      (byte_end && !l_reg.stop && l_reg.pend) |=> (l_reg.st == icw_pkg::L_BIT && l_reg.bitn == 4'h0);
  endproperty
  a_continue: assert property (p_continue) else $error("transfer did not continue"); // see RL3

  property p_hold;
    @(posedge link_clk) disable iff (!rst_b)
      (byte_end && !l_reg.stop && !l_reg.pend) |=> (l_reg.st == icw_pkg::L_HOLD && !scl_oe_b) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("scl not held low on empty queue"); // see RL4

  c_stop:  cover property (@(posedge link_clk) disable iff (!rst_b) byte_end && l_reg.stop);
  c_hold:  cover property (@(posedge link_clk) disable iff (!rst_b) l_reg.st == icw_pkg::L_HOLD);
  c_rx:    cover property (@(posedge ref_clk) disable iff (!rst_b) rx_push);
  c_abort: cover property (@(posedge ref_clk) disable iff (!rst_b) transmit_abort_flag);

endmodule

`default_nettype wire

//--- verif/icw_target_model.sv
// Purpose: behavioural i2c target sitting on the far side of the link
// Assumes: first byte after a start is written to it, the second is read from it
// Notes:   lets sda go outside those two bytes so the controller can form a stop
`timescale 1ns/1ps
`default_nettype none

module icw_target_model #(
  parameter logic [7:0] RD_BYTE = 8'h3c
) (
  // bus lines and pull
  input  wire logic scl,
  input  wire logic sda,
  output var  logic sda_pull_b
);
  int st      = 0;
  int st_seen = 0;
  int bc      = 0;
  int byc     = 2;

  always @(negedge sda) if (scl) st++;

  // bit slot count, 8 is the acknowledge slot
  always @(negedge scl) begin
    if (st != st_seen) begin
      st_seen = st;
      bc = 0;
      byc = 0;
    end else if (bc == 8) begin
      bc = 0;
      byc++;
    end else begin
      bc++;
    end
  end

  // data changes only while scl is low, as a real target would
  always_comb sda_pull_b = !((byc == 0 && bc == 8) || (byc == 1 && bc < 8 && !RD_BYTE[7 - bc]));
endmodule

`default_nettype wire

//--- verif/testbench.sv
// Purpose: self-checking bench for the command word and high-period block
// Assumes: short low period and a high count of six keep bytes brief
// Notes:   inputs change on the falling edge of ref_clk
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic ref_clk = 0, link_clk = 0, rst_b = 0;
  logic [7:0] reg_addr = 0, rx_head = 0, rx_push_byte;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic reg_wr = 0, reg_rd = 0, ctrl_enable = 0, target_mode = 0, gc_sent = 0, tar_target_select_a = 0, rd_req = 0;
  logic abort, bus_idle, tx_push, txq_valid = 0, txq_pop, rx_push, rx_empty = 1, rx_pop;
  logic [9:0] tx_word, txq_word = 0;
  logic scl_out, scl_oe_b, sda_out, sda_oe_b, pull_b;
  logic [15:0] hv [4] = '{16'h0000, 16'h0005, 16'h0006, 16'h0000};
  logic [7:0] pay;
  wire logic scl_w = scl_oe_b;
  wire logic sda_w = sda_oe_b & pull_b;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 84377;

  always #5 ref_clk = ~ref_clk;
  // offset keeps the two clocks apart in phase
  initial begin
    #3;
    forever #32 link_clk = ~link_clk;
  end

  icw_top #(.LOW_CNT(16'h0002)) dut_u (.ref_clk, .link_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .ctrl_enable, .target_mode, .gc_sent, .tar_target_select_a, .rd_req, .transmit_abort_flag(abort),
    .bus_idle, .tx_push, .tx_word, .txq_valid, .txq_word, .txq_pop, .rx_push, .rx_push_byte, .rx_empty,
    .rx_head, .rx_pop, .scl_in(scl_w), .scl_out, .scl_oe_b, .sda_in(sda_w), .sda_out, .sda_oe_b);
  icw_target_model tgt_u (.scl(scl_w), .sda(sda_w), .sda_pull_b(pull_b));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask

  function automatic logic [31:0] exp_hcnt(input logic [15:0] v);
    return {16'h0000, (v < icw_pkg::HCNT_MIN) ? icw_pkg::HCNT_MIN : v};
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    report_and_stop();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge ref_clk);
    #2 rst_b = 1'b1;
    rd(icw_pkg::OFS_SS_HCNT);
    chk("hcnt reset", {16'h0000, icw_pkg::HCNT_RESET}, reg_rdata);
    rd(8'h30);
    chk("unmapped read", 32'h0, reg_rdata);
    hv[3] = 16'($unsigned($random(seed)) % 32'd65519) + 16'h0007;
    for (int i = 0; i < 4; i++) begin
      wr(icw_pkg::OFS_SS_HCNT, {16'hffff, hv[i]});
      rd(icw_pkg::OFS_SS_HCNT);
      chk("hcnt", exp_hcnt(hv[i]), reg_rdata);
    end
    ctrl_enable = 1'b1;
    wr(icw_pkg::OFS_SS_HCNT, 32'h1234);
    rd(icw_pkg::OFS_SS_HCNT);
    chk("hcnt locked", exp_hcnt(hv[3]), reg_rdata);
    ctrl_enable = 1'b0;
    wr(icw_pkg::OFS_SS_HCNT, 32'h6);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      pay = 8'($random(seed));
      wr(icw_pkg::OFS_DATA_CMD, {22'h0, 2'(i), pay});
      chk("tx_push", 32'h1, tx_push);
      chk("tx_word", {22'h0, 2'(i), pay}, tx_word);
      rx_empty = 1'(i % 2);
      rx_head = 8'($random(seed));
      rd(icw_pkg::OFS_DATA_CMD);
      chk("rx_pop", {31'h0, ~rx_empty}, rx_pop);
      if (!rx_empty) chk("rdata", {24'h0, rx_head}, reg_rdata);
    end
    gc_sent = 1'b1;
    tar_target_select_a = 1'b1;
    wr(icw_pkg::OFS_DATA_CMD, 32'h100);
    chk("abort gc", 32'h1, abort);
    tar_target_select_a = 1'b0;
    wr(icw_pkg::OFS_DATA_CMD, 32'h100);
    chk("abort target_select_a clear", 32'h0, abort);
    gc_sent = 1'b0;
    target_mode = 1'b1;
    rd_req = 1'b1;
    @(negedge ref_clk);
    rd_req = 1'b0;
    wr(icw_pkg::OFS_DATA_CMD, 32'h100);
    chk("abort rd_req", 32'h1, abort);
    wr(icw_pkg::OFS_DATA_CMD, 32'h0aa);
    chk("abort target write", 32'h0, abort);
    target_mode = 1'b0;
    $display("test commands done");
    ctrl_enable = 1'b1;
    // idle needs the count plus ten link cycles of high lines, then two syncs
    for (int k = 0; k < 400 && bus_idle !== 1'b1; k++) @(negedge ref_clk);
    chk("idle before", 32'h1, bus_idle);
    txq_word = 10'h05a;
    txq_valid = 1'b1;
    for (int k = 0; k < 3000 && txq_pop !== 1'b1; k++) @(negedge ref_clk);
    txq_valid = 1'b0;
    chk("pop write", 32'h1, txq_pop);
    repeat (2500) @(negedge ref_clk);
    chk("scl held", 32'h0, scl_oe_b);
    chk("idle held", 32'h0, bus_idle);
    txq_word = 10'h300;
    txq_valid = 1'b1;
    for (int k = 0; k < 3000 && txq_pop !== 1'b1; k++) @(negedge ref_clk);
    txq_valid = 1'b0;
    chk("pop read", 32'h1, txq_pop);
    for (int k = 0; k < 3000 && rx_push !== 1'b1; k++) @(negedge ref_clk);
    chk("rx_push", 32'h1, rx_push);
    chk("rx byte", 32'h3c, rx_push_byte);
    repeat (800) @(negedge ref_clk);
    chk("idle after stop", 32'h1, bus_idle);
    chk("released", 32'h3, {scl_oe_b, sda_oe_b});
    chk("pin levels", 32'h0, {scl_out, sda_out});
    $display("test link done");
    report_and_stop();
  end
endmodule

`default_nettype wire
